// file: hw/bcrx_consts.svh
`ifndef BCRX_CONSTS_SVH
`define BCRX_CONSTS_SVH
`define BCRX_ADDR_ALL 8'hFF
`define BCRX_RC_START 4'h8
`define BCRX_RC_FULL 4'h9
`define BCRX_RC_END 4'hA
`define BCRX_RC_ABORT 4'hB
`define BCRX_RC_ERROR 4'hC
`define BCRX_FIFO_DEPTH 40
`define BCRX_HDR_ROOM 4
`define BCRX_CTL_STAT_A 4'h0
`define BCRX_CTL_STAT_B 4'h6
`define BCRX_FULL_WAIT_US 1570
`define BCRX_CLK_MHZ 50
`define BCRX_FULL_WAIT_CYC (`BCRX_FULL_WAIT_US * `BCRX_CLK_MHZ)
`endif

// file: hw/bcrx_pkg.sv
package bcrx_pkg;
    typedef struct packed {
        logic [11:0] masterAddr;
        logic [7:0] slaveAddr;
        logic broadcastBit;
        logic [3:0] control;
        logic [7:0] length;
    } bcrx_header_t;
    typedef enum logic [1:0] {
        BCRX_IDLE = 2'b00,
        BCRX_DATA = 2'b01,
        BCRX_FULL = 2'b10
    } bcrx_state_t;
endpackage

// file: hw/broadcast_rx_status.sv
`timescale 1ns/100ps
`include "bcrx_consts.svh"
module broadcast_rx_status (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] groupAddr,
    input wire logic rx_error_report_option,
    input wire logic multi_frame_option,
    input wire logic rxEnableSet,
    input wire logic ctlValid,
    input wire bcrx_pkg::bcrx_header_t header,
    input wire logic lenValid,
    input wire logic dataValid,
    input wire logic [7:0] dataByte,
    input wire logic frameEnd,
    input wire logic fifoRead,
    output logic [7:0] fifoData,
    output logic fifoEmpty,
    output logic [5:0] fifoCount,
    output logic [3:0] slave_return_code,
    output logic returnCodeStrobe,
    output logic slave_rx_enable_flag,
    output logic [7:0] slave_rx_byte_count,
    output logic [7:0] broadcast_address_low,
    output logic [7:0] broadcast_address_high,
    output logic statusBit1,
    output logic dataAck
);
    import bcrx_pkg::*;
    localparam int Depth = `BCRX_FIFO_DEPTH;
    logic [7:0] mem_reg [Depth];
    logic [7:0] mem_next [Depth];
    logic [5:0] wp_reg, wp_next, rp_reg, rp_next, cnt_reg, cnt_next;
    bcrx_state_t st_reg, st_next;
    logic [3:0] rc_reg, rc_next;
    logic rcs_reg, rcs_next, en_reg, en_next, rdy_reg, rdy_next, hit_reg, hit_next;
    logic ack_reg, ack_next;
    logic [7:0] bc_reg, bc_next, len_reg, len_next, dl_reg, dl_next, dh_reg, dh_next;
    bcrx_header_t hdr_reg, hdr_next;
    logic [16:0] tmr_reg, tmr_next;
    logic isBcast, fifoReady, doRead;

    function automatic logic [5:0] bump(input logic [5:0] p);
        bump = (p == 6'(Depth - 1)) ? 6'h00 : p + 6'h01;
    endfunction

    assign isBcast = !header.broadcastBit &&
        (header.slaveAddr == `BCRX_ADDR_ALL || header.slaveAddr == groupAddr);
    assign fifoReady = en_reg && (multi_frame_option ?
        (6'(Depth) - cnt_reg >= 6'(`BCRX_HDR_ROOM)) : (cnt_reg == 6'h00));
    assign doRead = fifoRead && cnt_reg != 6'h00;

    always_comb
    begin
        logic [5:0] w;
        logic [5:0] c;
        w = wp_reg;
        c = cnt_reg;
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = doRead ? bump(rp_reg) : rp_reg;
        st_next = st_reg;
        rc_next = rc_reg;
        rcs_next = 1'b0;
        en_next = en_reg | rxEnableSet;
        rdy_next = rdy_reg;
        hit_next = hit_reg;
        ack_next = 1'b0;
        bc_next = bc_reg;
        len_next = len_reg;
        dl_next = dl_reg;
        dh_next = dh_reg;
        hdr_next = hdr_reg;
        tmr_next = tmr_reg;
        if (doRead)
        begin
            c = c - 6'h01;
        end
        if (ctlValid && st_reg == BCRX_IDLE)
        begin
            hit_next = isBcast;
            rdy_next = fifoReady;
            hdr_next = header;
            if (isBcast && !fifoReady && rx_error_report_option)
            begin
                rc_next = `BCRX_RC_ERROR;
                rcs_next = 1'b1;
                dl_next = header.masterAddr[7:0];
                dh_next = {4'h0, header.masterAddr[11:8]};
            end
        end
        if (lenValid && st_reg == BCRX_IDLE && hit_reg && rdy_reg)
        begin
            // Room for the header was checked at the control field
            mem_next[w] = hdr_reg.masterAddr[11:4];
            w = bump(w);
            mem_next[w] = {hdr_reg.masterAddr[3:0], hdr_reg.control};
            w = bump(w);
            mem_next[w] = header.length;
            w = bump(w);
            c = c + 6'h03;
            len_next = header.length;
            bc_next = 8'h00;
            rc_next = `BCRX_RC_START;
            rcs_next = 1'b1;
            st_next = BCRX_DATA;
            hit_next = 1'b0;
        end
        if (st_reg == BCRX_FULL)
        begin
            tmr_next = tmr_reg + 17'h00001;
            if (doRead)
            begin
                st_next = BCRX_DATA;
            end
            else if (tmr_reg >= 17'(`BCRX_FULL_WAIT_CYC - 1) || frameEnd)
            begin
                rc_next = `BCRX_RC_ABORT;
                rcs_next = 1'b1;
                en_next = 1'b0;
                st_next = BCRX_IDLE;
            end
        end
        else if (st_reg == BCRX_DATA)
        begin
            if (dataValid && c != 6'(Depth))
            begin
                mem_next[w] = dataByte;
                w = bump(w);
                c = c + 6'h01;
                bc_next = bc_reg + 8'h01;
                ack_next = 1'b1;
                if (bc_reg + 8'h01 == len_reg)
                begin
                    rc_next = `BCRX_RC_END;
                    rcs_next = 1'b1;
                    en_next = 1'b0;
                    st_next = BCRX_IDLE;
                end
                else if (c == 6'(Depth))
                begin
                    rc_next = `BCRX_RC_FULL;
                    rcs_next = 1'b1;
                    tmr_next = 17'h00000;
                    st_next = BCRX_FULL;
                end
            end
            else if (frameEnd || dataValid)
            begin
                rc_next = `BCRX_RC_ABORT;
                rcs_next = 1'b1;
                en_next = 1'b0;
                st_next = BCRX_IDLE;
            end
        end
        wp_next = w;
        cnt_next = c;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < Depth; i++)
            begin
                mem_reg[i] <= 8'h00;
            end
            wp_reg <= 6'h00;
            rp_reg <= 6'h00;
            cnt_reg <= 6'h00;
            st_reg <= BCRX_IDLE;
            rc_reg <= 4'h0;
            rcs_reg <= 1'b0;
            en_reg <= 1'b0;
            rdy_reg <= 1'b0;
            hit_reg <= 1'b0;
            ack_reg <= 1'b0;
            bc_reg <= 8'h00;
            len_reg <= 8'h00;
            dl_reg <= 8'h00;
            dh_reg <= 8'h00;
            hdr_reg <= '0;
            tmr_reg <= 17'h00000;
        end
        else
        begin
            mem_reg <= mem_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            st_reg <= st_next;
            rc_reg <= rc_next;
            rcs_reg <= rcs_next;
            en_reg <= en_next;
            rdy_reg <= rdy_next;
            hit_reg <= hit_next;
            ack_reg <= ack_next;
            bc_reg <= bc_next;
            len_reg <= len_next;
            dl_reg <= dl_next;
            dh_reg <= dh_next;
            hdr_reg <= hdr_next;
            tmr_reg <= tmr_next;
        end
    end

    assign fifoData = mem_reg[rp_reg];
    assign fifoEmpty = cnt_reg == 6'h00;
    assign fifoCount = cnt_reg;
    assign slave_return_code = rc_reg;
    assign returnCodeStrobe = rcs_reg;
    assign slave_rx_enable_flag = en_reg;
    assign slave_rx_byte_count = bc_reg;
    assign broadcast_address_low = dl_reg;
    assign broadcast_address_high = dh_reg;
    // Answer 0 only for the two status requests
    assign statusBit1 = !(fifoReady && (header.control == `BCRX_CTL_STAT_A ||
        header.control == `BCRX_CTL_STAT_B));
    assign dataAck = ack_reg;

    start_code_a: assert property (@(posedge clk) disable iff (!rstn)
        (lenValid && st_reg == BCRX_IDLE && hit_reg && rdy_reg) |=> (rc_reg == `BCRX_RC_START && cnt_reg >= 6'h03))
        else $error("start code missing");
    end_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        (rcs_reg && (rc_reg == `BCRX_RC_END || rc_reg == `BCRX_RC_ABORT)) |-> !en_reg)
        else $error("enable flag not cleared");
    fifo_bound_a: assert property (@(posedge clk) disable iff (!rstn) cnt_reg <= 6'(Depth))
        else $error("fifo overfilled");
    full_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_reg == BCRX_FULL) |-> tmr_reg < 17'(`BCRX_FULL_WAIT_CYC))
        else $error("full wait exceeded");
    // Checked against en_reg, cnt_reg and the inputs, not against the ready term itself
    ready_empty_a: assert property (@(posedge clk) disable iff (!rstn)
        (ctlValid && st_reg == BCRX_IDLE && !multi_frame_option && (!en_reg || cnt_reg != 6'h00)) |=> !rdy_reg)
        else $error("ready without empty fifo");
    full_code_a: assert property (@(posedge clk) disable iff (!rstn)
        (rcs_reg && rc_reg == `BCRX_RC_FULL) |-> (cnt_reg == 6'(Depth) && st_reg == BCRX_FULL))
        else $error("full code with room left");
    end_count_a: assert property (@(posedge clk) disable iff (!rstn)
        (rcs_reg && rc_reg == `BCRX_RC_END) |-> (slave_rx_byte_count == len_reg && !en_reg))
        else $error("end code before length reached");
endmodule

// file: verif/bcrx_master_model.sv
`timescale 1ns/100ps
module bcrx_master_model (
    input wire logic clk,
    output bcrx_pkg::bcrx_header_t header,
    output logic ctlValid,
    output logic lenValid,
    output logic dataValid,
    output logic [7:0] dataByte,
    output logic frameEnd
);
    import bcrx_pkg::*;
    initial
    begin
        header = '0;
        ctlValid = 1'h0;
        lenValid = 1'h0;
        dataValid = 1'h0;
        dataByte = 8'h00;
        frameEnd = 1'h0;
    end
    // Spent fields are inverted so a stale value never passes
    task automatic sendHead(input bcrx_header_t h);
        @(negedge clk);
        header = h;
        ctlValid = 1'h1;
        @(negedge clk);
        ctlValid = 1'h0;
        lenValid = 1'h1;
        @(negedge clk);
        lenValid = 1'h0;
        header = ~h;
    endtask
    task automatic sendData(input int n, input logic [7:0] first);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk);
            dataValid = 1'h1;
            dataByte = first + 8'(i);
            @(negedge clk);
            dataValid = 1'h0;
            dataByte = ~dataByte;
        end
    endtask
    task automatic endFrame;
        @(negedge clk);
        frameEnd = 1'h1;
        @(negedge clk);
        frameEnd = 1'h0;
    endtask
    task automatic askStatus(input logic [3:0] c);
        @(negedge clk);
        header.control = c;
        header.broadcastBit = 1'h1;
    endtask
endmodule

// file: verif/broadcast_rx_status_bench.sv
`timescale 1ns/100ps
`include "bcrx_consts.svh"
module broadcast_rx_status_bench;
    import bcrx_pkg::*;
    logic clk;
    logic rstn;
    logic [7:0] groupAddr;
    logic rx_error_report_option;
    logic multi_frame_option;
    logic rxEnableSet;
    logic fifoRead;
    bcrx_header_t header;
    logic ctlValid;
    logic lenValid;
    logic dataValid;
    logic [7:0] dataByte;
    logic frameEnd;
    logic [7:0] fifoData;
    logic fifoEmpty;
    logic [5:0] fifoCount;
    logic [3:0] slave_return_code;
    logic slave_rx_enable_flag;
    logic [7:0] slave_rx_byte_count;
    logic [7:0] broadcast_address_low;
    logic [7:0] broadcast_address_high;
    logic statusBit1;
    logic returnCodeStrobe;
    logic dataAck;
    int nAck;
    int nFail;
    int testsRun;
    int cycles;
    logic [7:0] drain [9] = '{8'hAB, 8'hC5, 8'h02, 8'h11, 8'h12, 8'h12, 8'h33, 8'h04, 8'h33};
    broadcast_rx_status broadcast_rx_status_inst (.clk(clk), .rstn(rstn), .groupAddr(groupAddr),
        .rx_error_report_option(rx_error_report_option), .multi_frame_option(multi_frame_option),
        .rxEnableSet(rxEnableSet), .ctlValid(ctlValid), .header(header), .lenValid(lenValid),
        .dataValid(dataValid), .dataByte(dataByte), .frameEnd(frameEnd), .fifoRead(fifoRead),
        .fifoData(fifoData), .fifoEmpty(fifoEmpty), .fifoCount(fifoCount), .slave_return_code(slave_return_code),
        .returnCodeStrobe(returnCodeStrobe), .slave_rx_enable_flag(slave_rx_enable_flag),
        .slave_rx_byte_count(slave_rx_byte_count),
        .broadcast_address_low(broadcast_address_low), .broadcast_address_high(broadcast_address_high),
        .statusBit1(statusBit1), .dataAck(dataAck));
    bcrx_master_model bcrx_master_model_inst (.clk(clk), .header(header), .ctlValid(ctlValid),
        .lenValid(lenValid), .dataValid(dataValid), .dataByte(dataByte), .frameEnd(frameEnd));
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        testsRun++;
        if (got !== exp)
        begin
            nFail++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp, input string what);
        checkByte({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask
    task automatic setFlag;
        @(negedge clk);
        rxEnableSet = 1'h1;
        @(negedge clk);
        rxEnableSet = 1'h0;
    endtask
    task automatic popCheck(input logic [7:0] exp);
        @(negedge clk);
        checkByte(fifoData, exp, "fifo head");
        fifoRead = 1'h1;
        @(negedge clk);
        fifoRead = 1'h0;
    endtask
    // Status bit is combinational, so let it settle after the control change
    task automatic statusCheck(input logic exp);
        bcrx_master_model_inst.askStatus(`BCRX_CTL_STAT_A);
        #1;
        checkBit(statusBit1, exp, "status 0000");
        bcrx_master_model_inst.askStatus(`BCRX_CTL_STAT_B);
        #1;
        checkBit(statusBit1, exp, "status 0110");
        bcrx_master_model_inst.askStatus(4'h3);
        #1;
        checkBit(statusBit1, 1'h1, "status other");
    endtask
    task automatic endCheck(input logic [3:0] code, input logic [7:0] cnt);
        settle();
        checkByte({4'h0, slave_return_code}, {4'h0, code}, "end code");
        checkBit(slave_rx_enable_flag, 1'h0, "flag");
        checkByte(slave_rx_byte_count, cnt, "rx count");
    endtask
    task automatic headCheck(input bcrx_header_t h, input logic [3:0] code);
        bcrx_master_model_inst.sendHead(h);
        checkBit(returnCodeStrobe, code == `BCRX_RC_START, "start strobe");
        settle();
        checkByte({4'h0, slave_return_code}, {4'h0, code}, "head code");
    endtask
    task automatic printVerdict;
        $display("Compared %0d, mismatched %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (dataAck === 1'h1)
            nAck++;
    end
    // Whole run needs under two hundred cycles; the ceiling leaves wide margin
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            nFail++;
            printVerdict();
        end
    end
    initial
    begin
        rstn = 1'h0;
        groupAddr = 8'h5A;
        rx_error_report_option = 1'h0;
        multi_frame_option = 1'h0;
        rxEnableSet = 1'h0;
        fifoRead = 1'h0;
        nFail = 0;
        testsRun = 0;
        cycles = 0;
        nAck = 0;
        repeat (8) @(negedge clk);
        rstn = 1'h1;
        checkByte({4'h0, slave_return_code}, 8'h00, "reset code");
        checkBit(fifoEmpty, 1'h1, "reset empty");
        statusCheck(1'h1);
        setFlag();
        statusCheck(1'h0);
        headCheck('{12'hABC, `BCRX_ADDR_ALL, 1'h0, 4'h5, 8'h02}, `BCRX_RC_START);
        checkByte({2'h0, fifoCount}, 8'h03, "header bytes");
        bcrx_master_model_inst.sendData(2, 8'h11);
        endCheck(`BCRX_RC_END, 8'h02);
        $display("test normal end done");
        setFlag();
        headCheck('{12'hABC, `BCRX_ADDR_ALL, 1'h1, 4'h5, 8'h02}, `BCRX_RC_END);
        checkByte({2'h0, fifoCount}, 8'h05, "ignored frame");
        statusCheck(1'h1);
        multi_frame_option = 1'h1;
        statusCheck(1'h0);
        headCheck('{12'h123, 8'h5A, 1'h0, 4'h3, 8'h04}, `BCRX_RC_START);
        bcrx_master_model_inst.sendData(1, 8'h33);
        bcrx_master_model_inst.endFrame();
        endCheck(`BCRX_RC_ABORT, 8'h01);
        rx_error_report_option = 1'h1;
        headCheck('{12'h9E7, `BCRX_ADDR_ALL, 1'h0, 4'h2, 8'h01}, `BCRX_RC_ERROR);
        checkByte(broadcast_address_low, 8'hE7, "addr low");
        checkByte(broadcast_address_high, 8'h09, "addr high");
        $display("test abort and error done");
        foreach (drain[i])
            popCheck(drain[i]);
        checkBit(fifoEmpty, 1'h1, "drained");
        rx_error_report_option = 1'h0;
        setFlag();
        headCheck('{12'h456, `BCRX_ADDR_ALL, 1'h0, 4'h1, 8'h28}, `BCRX_RC_START);
        bcrx_master_model_inst.sendData(37, 8'h40);
        settle();
        checkByte({4'h0, slave_return_code}, {4'h0, `BCRX_RC_FULL}, "full code");
        checkByte({2'h0, fifoCount}, 8'h28, "full count");
        popCheck(8'h45);
        bcrx_master_model_inst.sendData(1, 8'h65);
        settle();
        checkByte({2'h0, fifoCount}, 8'h28, "resumed");
        bcrx_master_model_inst.endFrame();
        endCheck(`BCRX_RC_ABORT, 8'h26);
        popCheck(8'h61);
        checkByte(8'(nAck), 8'h29, "stored byte acks");
        $display("test buffer full done");
        printVerdict();
    end
endmodule
